// >>> rtl/dbmi_fifo.sv
`timescale 1ns/10ps
module dbmi_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW-1:0] rp_nxt;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	logic in_ready_r;
	logic out_valid_r;
	logic [WIDTH-1:0] out_data_r;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction

	// Flags and head word registered so every output leaves a flop
	assign in_ready = in_ready_r;
	assign out_valid = out_valid_r;
	assign out_data = out_data_r;
	assign push = in_valid && in_ready_r;
	assign pop = out_valid_r && out_ready;
	assign rp_nxt = pop ? wrap_inc(rp_r) : rp_r;
	assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge ref_clk)
	begin
		if (ce && push)
			mem[wp_r] <= in_data;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_ready_r <= 1'b1;
			out_valid_r <= 1'b0;
		end
		else if (ce)
		begin
			if (push)
				wp_r <= wrap_inc(wp_r);
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			in_ready_r <= cnt_nxt != (AW+1)'(DEPTH);
			out_valid_r <= cnt_nxt != '0;
		end
	end

	// Word pushed into an emptying buffer bypasses the array
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			out_data_r <= '0;
		else if (ce)
			out_data_r <= (push && rp_nxt == wp_r) ? in_data : mem[rp_nxt];
	end
endmodule

// >>> rtl/dbmi_lane.sv
`timescale 1ns/10ps
module dbmi_lane (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic mr_load,
	input wire logic [dbmi_pkg::MR_W-1:0] mr3_val,
	input wire logic [dbmi_pkg::MR_W-1:0] mode_reg_thirteen_val,
	input wire dbmi_pkg::dbmi_op_t op,
	input wire dbmi_pkg::dbmi_train_t train,
	input wire logic wr_beat_valid,
	input wire logic [dbmi_pkg::DQ_W-1:0] wr_dq,
	input wire logic [dbmi_pkg::LANES-1:0] line_in,
	output logic wr_beat_ready,
	output logic arr_valid,
	input wire logic arr_ready,
	output dbmi_pkg::dbmi_wbeat_t arr_beat,
	input wire logic rd_valid,
	input wire logic [dbmi_pkg::DQ_W-1:0] rd_data,
	output dbmi_pkg::dbmi_rbeat_t rd_out,
	output logic [dbmi_pkg::LANES-1:0] line_out,
	output logic [dbmi_pkg::LANES-1:0] line_oe_n,
	output logic line_rx_en,
	output logic illegal_mwrite,
	output logic excess_mwrite
);
	localparam int BW = dbmi_pkg::BYTE_W;
	localparam int NL = dbmi_pkg::LANES;
	localparam int BCW = $clog2(dbmi_pkg::BL_MASKED) + 1;

	logic mask_en_r;
	logic wr_inv_en_r;
	logic rd_inv_en_r;
	logic [NL-1:0] pattern_r;
	logic [BCW-1:0] beat_cnt_r;
	logic fifo_in_ready;
	logic fifo_push;
	dbmi_pkg::dbmi_wbeat_t dec_beat;
	logic [NL-1:0] enc_line;
	logic [dbmi_pkg::DQ_W-1:0] enc_data;

	function automatic logic [3:0] ones8(input logic [BW-1:0] b);
		logic [3:0] n;
		n = '0;
		for (int i = 0; i < BW; i++)
			n = n + 4'(b[i]);
		return n;
	endfunction

	function automatic logic [3:0] ones_hi6(input logic [BW-1:0] b);
		logic [3:0] n;
		n = '0;
		for (int i = dbmi_pkg::MASK_LO_BIT; i < BW; i++)
			n = n + 4'(b[i]);
		return n;
	endfunction

	// Mode enables latched from mode registers
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			mask_en_r <= 1'b0;
			wr_inv_en_r <= 1'b0;
			rd_inv_en_r <= 1'b0;
		end
		else if (ce && mr_load)
		begin
			mask_en_r <= mode_reg_thirteen_val[dbmi_pkg::MODE_REG_THIRTEEN_MASK_BIT];
			wr_inv_en_r <= mr3_val[dbmi_pkg::MR3_WR_INV_BIT];
			rd_inv_en_r <= mr3_val[dbmi_pkg::MR3_RD_INV_BIT];
		end
	end

	// Write decode, one byte lane at a time
	always_comb
	begin
		dec_beat.data = wr_dq;
		dec_beat.keep = '1;
		for (int l = 0; l < NL; l++)
		begin
			if (train == dbmi_pkg::DBMI_TR_NONE)
			begin
				if (op == dbmi_pkg::DBMI_OP_MWRITE && mask_en_r && !wr_inv_en_r)
					dec_beat.keep[l] = !line_in[l];
				else if (op == dbmi_pkg::DBMI_OP_MWRITE && mask_en_r)
				begin
					if (!line_in[l] && ones_hi6(wr_dq[l*BW +: BW]) >= 4'(dbmi_pkg::MASK_AT_LEAST))
						dec_beat.keep[l] = 1'b0;
					else if (line_in[l])
						dec_beat.data[l*BW +: BW] = ~wr_dq[l*BW +: BW];
				end
				else if (op == dbmi_pkg::DBMI_OP_WRITE && wr_inv_en_r && line_in[l])
					dec_beat.data[l*BW +: BW] = ~wr_dq[l*BW +: BW];
			end
		end
	end

	// Receivers on only when the line carries meaning
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			line_rx_en <= 1'b0;
		else if (ce)
			line_rx_en <= mask_en_r || wr_inv_en_r || train != dbmi_pkg::DBMI_TR_NONE;
	end

	// Masked write with masking off: flag, and the beat is dropped below
	assign fifo_push = wr_beat_valid
		&& !(op == dbmi_pkg::DBMI_OP_MWRITE && !mask_en_r)
		&& !(op == dbmi_pkg::DBMI_OP_MWRITE && beat_cnt_r >= BCW'(dbmi_pkg::BL_MASKED))
		&& train != dbmi_pkg::DBMI_TR_WFIFO;
	assign wr_beat_ready = fifo_in_ready;

	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			illegal_mwrite <= 1'b0;
			excess_mwrite <= 1'b0;
			beat_cnt_r <= '0;
		end
		else if (ce)
		begin
			illegal_mwrite <= wr_beat_valid && op == dbmi_pkg::DBMI_OP_MWRITE && !mask_en_r;
			excess_mwrite <= wr_beat_valid && op == dbmi_pkg::DBMI_OP_MWRITE
				&& beat_cnt_r >= BCW'(dbmi_pkg::BL_MASKED);
			if (op != dbmi_pkg::DBMI_OP_MWRITE)
				beat_cnt_r <= '0;
			else if (wr_beat_valid && fifo_in_ready && beat_cnt_r < BCW'(dbmi_pkg::BL_MASKED))
				beat_cnt_r <= beat_cnt_r + 1'b1;
		end
	end

	// Training pattern captured from the line, not applied to data
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			pattern_r <= '0;
		else if (ce && train == dbmi_pkg::DBMI_TR_WFIFO && wr_beat_valid)
			pattern_r <= line_in;
	end

	// Buffers decoded write beats toward the array; stalls the controller side
	dbmi_fifo #(
		.WIDTH($bits(dbmi_pkg::dbmi_wbeat_t)),
		.DEPTH(dbmi_pkg::FIFO_DEPTH)
	) u_wfifo (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.ce(ce),
		.in_valid(fifo_push && fifo_in_ready),
		.in_ready(fifo_in_ready),
		.in_data(dec_beat),
		.out_valid(arr_valid),
		.out_ready(arr_ready),
		.out_data(arr_beat)
	);

	// Read encode
	always_comb
	begin
		enc_data = rd_data;
		enc_line = '0;
		for (int l = 0; l < NL; l++)
		begin
			if (train == dbmi_pkg::DBMI_TR_RFIFO)
				enc_line[l] = pattern_r[l];
			else if (rd_inv_en_r && ones8(rd_data[l*BW +: BW]) > 4'(dbmi_pkg::RD_INV_ABOVE))
			begin
				enc_data[l*BW +: BW] = ~rd_data[l*BW +: BW];
				enc_line[l] = 1'b1;
			end
		end
	end

	// Drivers enabled only while a read beat leaves with inversion in use or during read-FIFO training
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			rd_out <= '0;
			line_out <= '0;
			line_oe_n <= '1;
		end
		else if (ce)
		begin
			rd_out.data <= rd_valid ? enc_data : '0;
			rd_out.line <= rd_valid ? enc_line : '0;
			line_out <= rd_valid ? enc_line : '0;
			if (rd_valid && (rd_inv_en_r || train == dbmi_pkg::DBMI_TR_RFIFO)
				&& (op == dbmi_pkg::DBMI_OP_READ || op == dbmi_pkg::DBMI_OP_MRR
				|| train == dbmi_pkg::DBMI_TR_RFIFO))
				line_oe_n <= '0;
			else
				line_oe_n <= '1;
		end
	end
endmodule

// >>> rtl/dbmi_pkg.sv
package dbmi_pkg;
	localparam int LANES = 2;
	localparam int BYTE_W = 8;
	localparam int DQ_W = 16;
	localparam int MR_W = 8;
	localparam int MR3_RD_INV_BIT = 6;
	localparam int MR3_WR_INV_BIT = 7;
	localparam int MODE_REG_THIRTEEN_MASK_BIT = 5;
	localparam int RD_INV_ABOVE = 4;
	localparam int MASK_AT_LEAST = 5;
	localparam int MASK_LO_BIT = 2;
	localparam int BL_MASKED = 16;
	localparam int FIFO_DEPTH = 32;
	localparam logic [MR_W-1:0] MR_RESET = 8'h00;

	typedef enum logic [4:0] {
		DBMI_OP_IDLE = 5'h01,
		DBMI_OP_WRITE = 5'h02,
		DBMI_OP_MWRITE = 5'h04,
		DBMI_OP_READ = 5'h08,
		DBMI_OP_MRR = 5'h10
	} dbmi_op_t;

	typedef enum logic [1:0] {
		DBMI_TR_NONE = 2'h0,
		DBMI_TR_WFIFO = 2'h1,
		DBMI_TR_RFIFO = 2'h2,
		DBMI_TR_RDCAL = 2'h3
	} dbmi_train_t;

	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic [LANES-1:0] keep;
	} dbmi_wbeat_t;

	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic [LANES-1:0] line;
	} dbmi_rbeat_t;
endpackage

// >>> tb/dbmi_ctrl_model.sv
`timescale 1ns/10ps
module dbmi_ctrl_model (
	input wire logic ref_clk,
	input wire logic wr_beat_ready,
	output logic wr_beat_valid = 1'b0,
	output logic [15:0] wr_dq = 16'h0000,
	output logic [1:0] line_in = 2'h0
);
	// Beat held until ready is seen at an edge; slow adds idle gaps
	task automatic send(input int n, input bit quiet, input bit slow);
		@(posedge ref_clk);
		repeat (n)
		begin
			wr_beat_valid <= 1'b1;
			wr_dq <= 16'($urandom);
			line_in <= quiet ? 2'h0 : 2'($urandom);
			do
				@(posedge ref_clk);
			while (!wr_beat_ready);
			if (slow)
			begin
				wr_beat_valid <= 1'b0;
				@(posedge ref_clk);
			end
		end
		// Released bus shows inverted junk, never the last beat
		wr_beat_valid <= 1'b0;
		wr_dq <= ~wr_dq;
		line_in <= ~line_in;
	endtask
endmodule

// >>> tb/dbmi_lane_asserts.sv
`timescale 1ns/10ps
module dbmi_lane_asserts (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic mr_load,
	input wire logic [7:0] mr3_val,
	input wire logic [7:0] mode_reg_thirteen_val,
	input wire dbmi_pkg::dbmi_op_t op,
	input wire dbmi_pkg::dbmi_train_t train,
	input wire logic wr_beat_valid,
	input wire logic wr_beat_ready,
	input wire logic [15:0] wr_dq,
	input wire logic [1:0] line_in,
	input wire logic arr_valid,
	input wire dbmi_pkg::dbmi_wbeat_t arr_beat,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	input wire dbmi_pkg::dbmi_rbeat_t rd_out,
	input wire logic [1:0] line_oe_n,
	input wire logic line_rx_en,
	input wire logic illegal_mwrite
);
	logic wi_r, ri_r, mk_r, wp, rp;
	// Shadow enables, loaded on the same edge as the design's
	always_ff @(posedge ref_clk)
		if (!rstn)
			{wi_r, ri_r, mk_r} <= 3'h0;
		else if (ce && mr_load)
			{wi_r, ri_r, mk_r} <= {mr3_val[7:6], mode_reg_thirteen_val[5]};
	// Empty buffer only, so the next output is this beat
	assign wp = wr_beat_valid && wr_beat_ready && ce && !arr_valid && !train;
	assign rp = rd_valid && ce && ri_r && !train && op[4:3] != 2'h0;
	function automatic logic [8:0] enc(logic [7:0] b);
		return $countones(b) > 4 ? {1'b1, ~b} : {1'b0, b};
	endfunction
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_rd_lane_lo: assert property (rp |=>
		{rd_out.line[0], rd_out.data[7:0]} == enc($past(rd_data[7:0]))) else $error("read code");
	a_rd_drive_on: assert property (rp |=> line_oe_n == 2'h0)
		else $error("read drive");
	a_rd_drive_off: assert property (ce && !ri_r && !train |=> &line_oe_n)
		else $error("drive when off");
	a_rx_off: assert property ((ce && !wi_r && !mk_r && !train)[*2] |=> !line_rx_en)
		else $error("receivers on");
	a_rx_on: assert property (ce && (wi_r || mk_r) |=> line_rx_en)
		else $error("receivers off");
	a_wr_invert: assert property (wp && wi_r && op[1] |=> arr_beat.data ==
		($past(wr_dq) ^ {{8{$past(line_in[1])}}, {8{$past(line_in[0])}}})) else $error("wr inv");
	a_mask_drop: assert property (wp && mk_r && !wi_r && op[2] |=>
		!arr_valid || arr_beat.keep == ~$past(line_in)) else $error("mask drop");
	a_mask_code: assert property (wp && mk_r && wi_r && op[2] |=> !arr_valid ||
		arr_beat.keep[0] == ($past(line_in[0]) || $countones($past(wr_dq[7:2])) < 5))
		else $error("mask code");
	a_illegal_cause: assert property (illegal_mwrite |-> $past(op[2]) && !$past(mk_r))
		else $error("illegal flag");
endmodule

// >>> tb/dbmi_lane_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
	$display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module dbmi_lane_tb;
	logic ref_clk = 1'b0, rstn = 1'b0, ce = 1'b1, mr_load = 1'b0, arr_ready = 1'b1;
	logic rd_valid = 1'b0, wr_beat_valid, wr_beat_ready, arr_valid, line_rx_en;
	logic illegal_mwrite, excess_mwrite, mk = 1'b0, wi = 1'b0, ri = 1'b0;
	logic [7:0] mr3_val = 8'h00, mode_reg_thirteen_val = 8'h00;
	logic [15:0] wr_dq, rd_data = 16'h0000, km;
	logic [1:0] line_in, line_out, line_oe_n;
	dbmi_pkg::dbmi_op_t op = dbmi_pkg::DBMI_OP_IDLE;
	dbmi_pkg::dbmi_train_t train = dbmi_pkg::DBMI_TR_NONE;
	dbmi_pkg::dbmi_wbeat_t arr_beat, e, q[$];
	dbmi_pkg::dbmi_rbeat_t rd_out;
	int n_fail = 0, cmp_count = 0, n_ill = 0, n_exc = 0, beats = 0;
	logic [1:0] pat = 2'h0;
	dbmi_lane i_dut (.*);
	dbmi_ctrl_model i_ctl (.*);
	assign km = {{8{arr_beat.keep[1]}}, {8{arr_beat.keep[0]}}};
	initial
		forever #5 ref_clk = ~ref_clk;
	// Masked bytes compare as zero whatever data they carry
	function automatic dbmi_pkg::dbmi_wbeat_t exp_w(logic [15:0] d, logic [1:0] l);
		logic [7:0] b;
		for (int i = 0; i < 2; i++)
		begin
			b = d[i*8 +: 8];
			exp_w.keep[i] = !(op[2] && (wi ? !l[i] && $countones(b[7:2]) > 4 : l[i]));
			exp_w.data[i*8 +: 8] = exp_w.keep[i] ? (wi && l[i] ? ~b : b) : 8'h00;
		end
	endfunction
	always @(posedge ref_clk)
	begin
		if (!op[2])
			beats = 0;
		if (wr_beat_valid && train == dbmi_pkg::DBMI_TR_WFIFO)
			pat = line_in;
		if (wr_beat_valid && wr_beat_ready && !train && (!op[2] || mk && beats++ < 16))
			q.push_back(exp_w(wr_dq, line_in));
		if (arr_valid && arr_ready)
		begin
			e = q.pop_front();
			`CHK({arr_beat.data & km, arr_beat.keep}, e)
		end
		n_ill += illegal_mwrite;
		n_exc += excess_mwrite;
	end
	task automatic rd(input dbmi_pkg::dbmi_op_t o, input logic [15:0] d);
		dbmi_pkg::dbmi_rbeat_t x;
		@(posedge ref_clk);
		op <= o;
		@(posedge ref_clk);
		rd_valid <= 1'b1;
		rd_data <= d;
		@(posedge ref_clk);
		rd_valid <= 1'b0;
		rd_data <= ~d;
		@(negedge ref_clk);
		for (int i = 0; i < 2; i++)
			x.line[i] = ri && $countones(d[i*8 +: 8]) > 4;
		x.data = d ^ {{8{x.line[1]}}, {8{x.line[0]}}};
		`CHK({rd_out.data, rd_out.line, line_out, line_oe_n},
			{x, x.line, {2{!ri}}})
	endtask
	task automatic wr(input dbmi_pkg::dbmi_op_t o, input int n);
		@(posedge ref_clk);
		op <= o;
		i_ctl.send(n, mk && !wi && o[1], 1'($urandom));
		repeat (4)
			@(posedge ref_clk);
	endtask
	task automatic mode(input logic [2:0] m);
		@(posedge ref_clk);
		{mk, wi, ri} <= m;
		mr_load <= 1'b1;
		mode_reg_thirteen_val <= {2'($urandom), m[2], 5'($urandom)};
		mr3_val <= {m[1:0], 6'($urandom)};
		@(posedge ref_clk);
		mr_load <= 1'b0;
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_fail++;
		finish_test();
	end
	initial
	begin
		void'($urandom(32'h3f89c7b6));
		repeat (2)
			@(posedge ref_clk);
		rstn <= 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			mode(3'(m));
			wr(dbmi_pkg::DBMI_OP_WRITE, 1 + $urandom_range(20));
			wr(dbmi_pkg::DBMI_OP_MWRITE, 18);
			rd(dbmi_pkg::DBMI_OP_READ, 16'hF80F);
			rd(dbmi_pkg::DBMI_OP_MRR, 16'($urandom));
			$display("mode %0d done", m);
		end
		@(posedge ref_clk);
		train <= dbmi_pkg::DBMI_TR_WFIFO;
		wr(dbmi_pkg::DBMI_OP_WRITE, 4);
		train <= dbmi_pkg::DBMI_TR_RFIFO;
		rd_valid <= 1'b1;
		@(posedge ref_clk);
		train <= dbmi_pkg::DBMI_TR_NONE;
		rd_valid <= 1'b0;
		arr_ready <= 1'b0;
		@(negedge ref_clk);
		`CHK({line_out, line_oe_n, rd_out.data}, {pat, 2'h0, rd_data})
		fork
			wr(dbmi_pkg::DBMI_OP_WRITE, 40);
			begin
				// Slow sender needs about two cycles a beat to fill the buffer
				repeat (80)
					@(posedge ref_clk);
				`CHK(wr_beat_ready, 1'b0)
				arr_ready <= 1'b1;
			end
		join
		repeat (dbmi_pkg::FIFO_DEPTH + 8)
			@(posedge ref_clk);
		`CHK(q.size(), 0)
		`CHK(n_ill, 4 * 18)
		`CHK(n_exc, 8 * (18 - dbmi_pkg::BL_MASKED))
		$display("buffer and training done");
		finish_test();
	end
endmodule
bind dbmi_lane dbmi_lane_asserts i_chk (.*);
